// ===== core/tw_core.sv
/*
  Periodic timer and watchdog core with an APB register slave.
  Assumes SLOW_TICK_IN is a one-cycle pulse per slow clock rising
  edge, synchronous to CLK_IN; CE_IN low is halt mode.
*/
`timescale 1ns/1ps
module tw_core
  import tw_pkg::*;
#(
  parameter int TMR_W = 16,
  parameter int WD_W  = 8
) (
  // Clock, reset, halt
  input  wire logic        CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        CE_IN,
  // Slow clock tick and power mode
  input  wire logic        SLOW_TICK_IN,
  input  wire logic        ACTIVE_MODE_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Events
  output logic             TIMER_ZERO_PULSE_OUT,
  output logic             PERIODIC_TIMER_IRQ_OUT,
  output logic             WATCHDOG_ERROR_OUT
);

  // ---------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------
  if (TMR_W != 16 || WD_W != 8) begin : g_bad_width
    $error("tw_core supports only a 16-bit timer and 8-bit watchdog");
  end

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [TW_PRE_CNT_W-1:0] pre_cnt;
    logic [TW_CFG_W-1:0]     cfg;
    logic [TW_DIV_SEL_W-1:0] div_sel;
    logic [TMR_W-1:0]        preset;
    logic [TMR_W-1:0]        t_cnt;
    logic                    zero;
    logic                    restart;
    logic                    tc;
    logic                    irq_en;
    logic                    irq;
    logic [WD_W-1:0]         wd_reload;
    logic [WD_W-1:0]         wd_cnt;
    logic                    wd_run;
    logic                    wd_keyed;
    logic                    wd_err;
    logic [31:0]             rdata;
    logic                    slverr;
  } tw_state_t;

  tw_state_t st_q;
  tw_state_t st_d;

  // ---------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------
  logic                    setup;
  logic                    access;
  logic                    wr;
  logic                    rd;
  logic                    mapped;
  logic                    allowed;
  logic                    locked;
  logic [TW_PRE_CNT_W-1:0] div_last;
  logic                    tick;
  logic                    wd_tick;
  logic [7:0]              wbyte;

  // Bus phases; setup latches read data and error, access does writes and read clears
  assign setup  = PSEL_IN & ~PENABLE_IN;
  assign access = PSEL_IN & PENABLE_IN;
  assign wr     = access & PWRITE_IN;
  assign rd     = access & ~PWRITE_IN;
  assign wbyte  = PWDATA_IN[7:0];

  // Address map and lock decode
  always_comb begin
    mapped = 1'b1;
    locked = 1'b0;
    unique case (PADDR_IN)
      TW_OFS_CONFIG:    locked = st_q.cfg[TW_CFG_LOCK_CFG];
      TW_OFS_PRESCALER: locked = st_q.cfg[TW_CFG_LOCK_PRE];
      TW_OFS_PRESET:    locked = st_q.cfg[TW_CFG_LOCK_TMR];
      TW_OFS_CTRL:      locked = st_q.cfg[TW_CFG_LOCK_TMR];
      TW_OFS_RELOAD:    locked = st_q.cfg[TW_CFG_LOCK_RLD];
      TW_OFS_KEY:       locked = 1'b0;
      default:          mapped = 1'b0;
    endcase
  end

  // Outside active mode only the key register answers
  assign allowed = mapped & ~locked &
                   (ACTIVE_MODE_IN | (PADDR_IN == TW_OFS_KEY));

  // Divider terminal: reserved selects behave as the largest divisor
  always_comb begin
    if (st_q.div_sel > TW_DIV_SEL_MAX) begin
      div_last = '1;
    end else begin
      div_last = TW_PRE_CNT_W'((6'h01 << st_q.div_sel) - 6'h01);
    end
  end

  // Prescaled tick edge and the selected watchdog clock edge
  assign tick    = SLOW_TICK_IN & (st_q.pre_cnt >= div_last);
  assign wd_tick = st_q.cfg[TW_CFG_CLK_SEL] ? tick :
                   (tick & ~st_q.restart &
                    (st_q.t_cnt == TMR_W'(1)));

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_d     = st_q;
    st_d.irq = 1'b0;

    // Prescaler counter
    if (SLOW_TICK_IN) begin
      st_d.pre_cnt = tick ? '0 : st_q.pre_cnt + 1'b1;
    end

    // Timer: a restart wins over counting on the same tick edge
    if (tick) begin
      if (st_q.restart) begin
        st_d.t_cnt   = st_q.preset;
        st_d.restart = 1'b0;
        st_d.zero    = 1'b0;
      end else if (st_q.t_cnt == '0) begin
        st_d.t_cnt = st_q.preset;
        st_d.zero  = 1'b0;
      end else begin
        st_d.t_cnt = st_q.t_cnt - 1'b1;
        st_d.zero  = (st_q.t_cnt == TMR_W'(1));
      end
    end

    // Watchdog counting; running down to zero is a late service
    if (wd_tick && st_q.wd_run) begin
      st_d.wd_keyed = 1'b0;
      if (st_q.wd_cnt <= WD_W'(1)) begin
        st_d.wd_err = 1'b1;
        st_d.wd_cnt = '0;
      end else begin
        st_d.wd_cnt = st_q.wd_cnt - 1'b1;
      end
    end

    // Read data and error answer are latched in the setup phase
    if (setup) begin
      st_d.slverr = ~mapped;
      st_d.rdata  = TW_RD_BLOCKED;
      if (allowed && !PWRITE_IN) begin
        unique case (PADDR_IN)
          TW_OFS_CONFIG:    st_d.rdata = 32'(st_q.cfg);
          TW_OFS_PRESCALER: st_d.rdata = 32'(st_q.div_sel);
          TW_OFS_PRESET:    st_d.rdata = 32'(st_q.preset);
          TW_OFS_CTRL: begin
            st_d.rdata[TW_CS_RESTART] = st_q.restart;
            st_d.rdata[TW_CS_TC]      = st_q.tc;
            st_d.rdata[TW_CS_IRQ_EN]  = st_q.irq_en;
          end
          default:          st_d.rdata = TW_RD_BLOCKED;
        endcase
      end
    end

    // Reading control/status clears the terminal count flag
    if (rd && allowed && PADDR_IN == TW_OFS_CTRL) begin
      st_d.tc = 1'b0;
    end

    // Register writes
    if (wr && allowed) begin
      unique case (PADDR_IN)
        TW_OFS_CONFIG: begin
          st_d.cfg = st_q.cfg | wbyte[TW_CFG_W-1:0];
        end
        TW_OFS_PRESCALER: begin
          st_d.div_sel = wbyte[TW_DIV_SEL_W-1:0];
        end
        TW_OFS_PRESET: begin
          st_d.preset = PWDATA_IN[TMR_W-1:0];
        end
        TW_OFS_CTRL: begin
          st_d.irq_en = wbyte[TW_CS_IRQ_EN];
          if (wbyte[TW_CS_RESTART]) begin
            st_d.restart = 1'b1;
          end
        end
        TW_OFS_RELOAD: begin
          st_d.wd_reload = wbyte;
          if (!st_q.cfg[TW_CFG_KEY_EN] || !st_q.wd_run) begin
            st_d.wd_cnt = wbyte;
          end
          st_d.wd_run = 1'b1;
        end
        TW_OFS_KEY: begin
          if (st_q.cfg[TW_CFG_KEY_EN]) begin
            st_d.wd_run   = 1'b1;
            st_d.wd_keyed = 1'b1;
            if (wbyte != TW_SERVICE_KEY) begin
              st_d.wd_err = 1'b1;
            end else if (st_q.wd_keyed) begin
              st_d.wd_err = 1'b1;
            end else begin
              st_d.wd_cnt = st_q.wd_reload;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // Zero event: flag and gated interrupt; set beats a read clear
    if (tick && !st_q.restart && st_q.t_cnt == TMR_W'(1)) begin
      st_d.tc  = 1'b1;
      st_d.irq = st_q.irq_en;
    end
  end

  // ---------------------------------------------------------------
  // Registers; CE_IN low is halt and freezes everything
  // ---------------------------------------------------------------
  always_ff @(posedge CLK_IN) begin
    if (RST_IN) begin
      st_q           <= '0;
      st_q.preset    <= TW_PRESET_RST;
      st_q.t_cnt     <= TW_PRESET_RST;
      st_q.wd_reload <= TW_RELOAD_RST;
      st_q.wd_cnt    <= TW_RELOAD_RST;
    end else if (CE_IN) begin
      st_q <= st_d;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign PRDATA_OUT             = st_q.rdata;
  assign PSLVERR_OUT            = st_q.slverr & access;
  assign PREADY_OUT             = access;
  assign TIMER_ZERO_PULSE_OUT   = st_q.zero;
  assign PERIODIC_TIMER_IRQ_OUT = st_q.irq;
  assign WATCHDOG_ERROR_OUT     = st_q.wd_err;

endmodule

// ===== common/tw_pkg.sv
/*
  Constants for the periodic timer and watchdog block: APB register
  offsets, field positions, reset values and encodings.
  Assumes a 32-bit APB slave with one register per aligned word.
*/
// Function
// - Timer is 16-bit down counter on tick
// - At zero, reload from preset and continue
// - Prescaler divides slow clock by 1..32
// - Zero pulse lasts one tick, sets flag
// - Zero pulse raises irq when enabled
// - Preset write waits for next reload
// - Reload request reloads next tick, self-clears
// - Watchdog is 8-bit down counter
// - Watchdog idle and silent after reset
// - Reload or key write starts watchdog; here a key write starts it only with key mode on
// - Only reset stops running watchdog
// - Config bit picks watchdog clock source
// - Key mode off: reload write reloads
// - Key mode on: key 5C reloads
// - Key mode on: other key errors
// - Late or frequent service errors, resets device
// - Lock bits block writes, reads unpredictable
// - Locks hold until device reset
// - Power save: only key register accessible
// - Halt freezes all, resumes exactly
// - Reading control clears terminal count flag
// - Config bits set-only, reset to zero
// - Reload value resets to 0F
// - Two key writes per watchdog tick error
package tw_pkg;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] TW_OFS_CONFIG    = 8'h00;
  localparam logic [7:0] TW_OFS_PRESCALER = 8'h04;
  localparam logic [7:0] TW_OFS_PRESET    = 8'h08;
  localparam logic [7:0] TW_OFS_CTRL      = 8'h0c;
  localparam logic [7:0] TW_OFS_RELOAD    = 8'h10;
  localparam logic [7:0] TW_OFS_KEY       = 8'h14;

  // ---------------------------------------------------------------
  // Watchdog config field positions
  // ---------------------------------------------------------------
  localparam int TW_CFG_W         = 6;
  localparam int TW_CFG_LOCK_CFG  = 0;
  localparam int TW_CFG_LOCK_PRE  = 1;
  localparam int TW_CFG_LOCK_TMR  = 2;
  localparam int TW_CFG_LOCK_RLD  = 3;
  localparam int TW_CFG_CLK_SEL   = 4;
  localparam int TW_CFG_KEY_EN    = 5;

  // ---------------------------------------------------------------
  // Timer control/status field positions
  // ---------------------------------------------------------------
  localparam int TW_CS_RESTART = 0;
  localparam int TW_CS_TC      = 1;
  localparam int TW_CS_IRQ_EN  = 2;

  // ---------------------------------------------------------------
  // Widths, reset values, encodings
  // ---------------------------------------------------------------
  localparam int          TW_DIV_SEL_W  = 3;
  localparam int          TW_PRE_CNT_W  = 5;
  localparam logic [2:0]  TW_DIV_SEL_MAX = 3'h5;
  localparam logic [15:0] TW_PRESET_RST = 16'hffff;
  localparam logic [7:0]  TW_RELOAD_RST = 8'h0f;
  localparam logic [7:0]  TW_SERVICE_KEY = 8'h5c;
  localparam logic [31:0] TW_RD_BLOCKED = 32'h0000_0000;

endpackage

// ===== sim/tw_chk_sva.sv
/*
  Port checker for tw_core: bus answer, timer events, watchdog error.
  Assumes one clock domain and the synchronous active-high reset.
*/
`timescale 1ns/1ps
module tw_chk
  import tw_pkg::*;
(
  // Clock, reset, halt, slow tick
  input wire logic       CLK_IN,
  input wire logic       RST_IN,
  input wire logic       CE_IN,
  input wire logic       SLOW_TICK_IN,
  // APB
  input wire logic       PSEL_IN,
  input wire logic       PENABLE_IN,
  input wire logic       PWRITE_IN,
  input wire logic [7:0] PADDR_IN,
  input wire logic       PREADY_OUT,
  input wire logic       PSLVERR_OUT,
  // Events
  input wire logic       TIMER_ZERO_PULSE_OUT,
  input wire logic       PERIODIC_TIMER_IRQ_OUT,
  input wire logic       WATCHDOG_ERROR_OUT
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  logic cause;
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (RST_IN);
  // A watchdog edge or a key write is the only source of an error
  assign cause = SLOW_TICK_IN || (PSEL_IN && PENABLE_IN && PWRITE_IN &&
                 PADDR_IN == TW_OFS_KEY);
  ready_in_access_a: assert property (PSEL_IN && PENABLE_IN |-> PREADY_OUT)
    else $error("access without ready");
  err_in_access_a: assert property (PSLVERR_OUT |-> PSEL_IN && PENABLE_IN)
    else $error("bus error outside access");
  irq_one_cycle_a: assert property (
    PERIODIC_TIMER_IRQ_OUT && CE_IN |=> !PERIODIC_TIMER_IRQ_OUT)
    else $error("irq pulse too long");
  irq_with_zero_a: assert property (
    $rose(PERIODIC_TIMER_IRQ_OUT) |-> $rose(TIMER_ZERO_PULSE_OUT))
    else $error("irq without zero event");
  zero_on_tick_a: assert property (
    $changed(TIMER_ZERO_PULSE_OUT) && !$past(RST_IN)
    |-> $past(SLOW_TICK_IN) && $past(CE_IN))
    else $error("zero pulse moved off tick");
  error_sticky_a: assert property (
    WATCHDOG_ERROR_OUT |=> WATCHDOG_ERROR_OUT)
    else $error("watchdog error dropped");
  error_cause_a: assert property (
    $rose(WATCHDOG_ERROR_OUT) && !$past(RST_IN)
    |-> $past(cause) || $past(cause, 2))
    else $error("watchdog error without cause");
  halt_freeze_a: assert property (
    !CE_IN |=> $stable(TIMER_ZERO_PULSE_OUT) && $stable(WATCHDOG_ERROR_OUT))
    else $error("state moved in halt");
  irq_seen_c: cover property ($rose(PERIODIC_TIMER_IRQ_OUT));
  error_seen_c: cover property ($rose(WATCHDOG_ERROR_OUT));
  slverr_seen_c: cover property (PSLVERR_OUT);
endmodule

bind tw_core tw_chk tw_chk_inst (.CLK_IN(CLK_IN), .RST_IN(RST_IN),
  .CE_IN(CE_IN), .SLOW_TICK_IN(SLOW_TICK_IN), .PSEL_IN(PSEL_IN),
  .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .TIMER_ZERO_PULSE_OUT(TIMER_ZERO_PULSE_OUT),
  .PERIODIC_TIMER_IRQ_OUT(PERIODIC_TIMER_IRQ_OUT),
  .WATCHDOG_ERROR_OUT(WATCHDOG_ERROR_OUT));

// ===== sim/tw_core_tb_top.sv
/*
  Self-checking bench for tw_core, driven over APB.
  Assumes a slow clock edge every fourth CLK_IN cycle.
*/
`timescale 1ns/1ps
module tw_core_tb_top;
  import tw_pkg::*;
  // ----------------------------------------------------------------
  // Stimulus and tasks
  // ----------------------------------------------------------------
  logic        CLK_IN = 0, RST_IN = 1, CE_IN = 1, SLOW_TICK_IN = 0;
  logic        ACTIVE_MODE_IN = 1, PSEL_IN = 0, PENABLE_IN = 0;
  logic        PWRITE_IN = 0, PREADY_OUT, PSLVERR_OUT, last_err;
  logic        TIMER_ZERO_PULSE_OUT, PERIODIC_TIMER_IRQ_OUT;
  logic        WATCHDOG_ERROR_OUT;
  logic [7:0]  PADDR_IN = '0;
  logic [31:0] PWDATA_IN = '0, PRDATA_OUT, rd;
  logic [1:0]  tick_cnt = '0;
  int          failures = 0, checks = 0, w, p, irq;

  tw_core tw_core_inst (.CLK_IN(CLK_IN), .RST_IN(RST_IN), .CE_IN(CE_IN),
    .SLOW_TICK_IN(SLOW_TICK_IN), .ACTIVE_MODE_IN(ACTIVE_MODE_IN),
    .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN),
    .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN), .PRDATA_OUT(PRDATA_OUT),
    .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
    .TIMER_ZERO_PULSE_OUT(TIMER_ZERO_PULSE_OUT),
    .PERIODIC_TIMER_IRQ_OUT(PERIODIC_TIMER_IRQ_OUT),
    .WATCHDOG_ERROR_OUT(WATCHDOG_ERROR_OUT));

  always #2.5 CLK_IN = ~CLK_IN;
  // Slow clock every fourth cycle keeps timer periods short
  always @(posedge CLK_IN) begin
    tick_cnt <= tick_cnt + 2'h1;
    SLOW_TICK_IN <= (tick_cnt == 2'h3);
  end

  task automatic chk(input logic [31:0] seen, exp, input string what);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // Each transfer opens on a fresh edge, so no signal is driven twice
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge CLK_IN);
    PSEL_IN <= 1'b1;
    PWRITE_IN <= wr;
    PADDR_IN <= a;
    PWDATA_IN <= d;
    @(posedge CLK_IN);
    PENABLE_IN <= 1'b1;
    // Wait for ready; only the run watchdog ends a stuck transfer
    do begin
      @(posedge CLK_IN);
    end while (PREADY_OUT !== 1'b1);
    rd = PRDATA_OUT;
    last_err = PSLVERR_OUT;
    PSEL_IN <= 1'b0;
    PENABLE_IN <= 1'b0;
  endtask

  // Cycles up to the next rise of the zero pulse, irq pulses seen meanwhile
  task automatic rise(output int n, output int irqs);
    logic prev;
    prev = TIMER_ZERO_PULSE_OUT;
    irqs = 0;
    for (n = 1; n < 5000; n++) begin
      @(posedge CLK_IN);
      irqs += (PERIODIC_TIMER_IRQ_OUT === 1'b1);
      if (TIMER_ZERO_PULSE_OUT === 1'b1 && prev === 1'b0) break;
      prev = TIMER_ZERO_PULSE_OUT;
    end
    // A pulse that never comes counts as a mismatch
    if (n >= 5000) failures++;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge CLK_IN);
  endtask

  task automatic rst;
    @(posedge CLK_IN);
    RST_IN <= 1'b1;
    cyc(5);
    RST_IN <= 1'b0;
  endtask

  task automatic end_sim;
    if (failures == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Watchdog on the whole run
  initial begin
    #200000;
    failures++;
    end_sim;
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    rst;
    apb(0, TW_OFS_CONFIG, 0);
    chk(rd, 0, "cfg");
    apb(0, TW_OFS_PRESET, 0);
    chk(rd, 32'h0000ffff, "preset");
    apb(0, 8'h18, 0);
    chk(last_err, 1, "unmapped");
    apb(1, TW_OFS_PRESET, 32'h3);
    apb(1, TW_OFS_CTRL, 32'h5);
    // Every divide setting, period is (preset+1) ticks
    for (int s = 0; s < 6; s++) begin
      apb(1, TW_OFS_PRESCALER, s);
      rise(w, irq);
      rise(p, irq);
      chk(p, (4 << s) * 4, "period");
      chk(irq, 1, "irq");
    end
    apb(0, TW_OFS_CTRL, 0);
    chk(rd, 32'h6, "ctrl");
    apb(0, TW_OFS_CTRL, 0);
    chk(rd, 32'h4, "ctrl clr");
    apb(1, TW_OFS_CTRL, 0);
    apb(1, TW_OFS_PRESCALER, 0);
    rise(w, irq);
    apb(1, TW_OFS_PRESET, 32'h7);
    rise(w, irq);
    chk(w <= 16, 1, "old preset");
    rise(p, irq);
    chk(p, 32, "new preset");
    chk(irq, 0, "masked");
    // Halt for five ticks right after a zero event; period resumes intact
    rise(w, irq);
    CE_IN <= 1'b0;
    cyc(20);
    CE_IN <= 1'b1;
    rise(p, irq);
    chk(p, 32, "resume");
    // Watchdog on the tick, serviced by reload writes, then starved
    apb(1, TW_OFS_CONFIG, 32'h10);
    repeat (4) begin
      apb(1, TW_OFS_RELOAD, 32'h20);
      cyc(60);
    end
    cyc(40);
    chk(WATCHDOG_ERROR_OUT, 0, "served");
    cyc(40);
    chk(WATCHDOG_ERROR_OUT, 1, "late");
    rst;
    chk(WATCHDOG_ERROR_OUT, 0, "after rst");
    // Key service with the zero event as watchdog clock
    apb(1, TW_OFS_PRESET, 32'h3);
    apb(1, TW_OFS_CTRL, 32'h1);
    apb(1, TW_OFS_CONFIG, 32'h20);
    apb(1, TW_OFS_RELOAD, 32'h10);
    repeat (3) begin
      cyc(100);
      apb(1, TW_OFS_KEY, TW_SERVICE_KEY);
    end
    chk(WATCHDOG_ERROR_OUT, 0, "key");
    rise(w, irq);
    apb(1, TW_OFS_KEY, TW_SERVICE_KEY);
    apb(1, TW_OFS_KEY, TW_SERVICE_KEY);
    cyc(2);
    chk(WATCHDOG_ERROR_OUT, 1, "twice");
    rst;
    apb(1, TW_OFS_CONFIG, 32'h20);
    apb(1, TW_OFS_KEY, 32'h33);
    cyc(2);
    chk(WATCHDOG_ERROR_OUT, 1, "bad key");
    rst;
    // Locks, set-only config, power save access
    apb(1, TW_OFS_PRESCALER, 32'h3);
    apb(1, TW_OFS_CONFIG, 32'h2);
    apb(1, TW_OFS_PRESCALER, 32'h5);
    apb(0, TW_OFS_PRESCALER, 0);
    chk(rd, TW_RD_BLOCKED, "locked");
    apb(1, TW_OFS_CONFIG, 0);
    apb(0, TW_OFS_CONFIG, 0);
    chk(rd, 2, "cfg set");
    // Restart, then wait fifteen slow clocks so it lands on a prescaled tick
    apb(1, TW_OFS_CTRL, 32'h1);
    cyc(60);
    apb(0, TW_OFS_CTRL, 0);
    chk(rd, 0, "restart done");
    ACTIVE_MODE_IN <= 1'b0;
    apb(1, TW_OFS_PRESET, 32'h55);
    apb(0, TW_OFS_PRESET, 0);
    chk(rd, 0, "saving");
    ACTIVE_MODE_IN <= 1'b1;
    apb(0, TW_OFS_PRESET, 0);
    chk(rd, 32'h0000ffff, "kept");
    end_sim;
  end
endmodule
